// ---- hdl/plc_link_control.sv ----
// link control register with retrain, disable and aspm controls
// ---------------------------------------------------------------
// Summary of operation
// R1: 16-bit register, resets to zero, bits 15:8 read zero.
// R2: bit 7 extended sync is read-write; zero means standard sequence.
// R3: bit 6 common clock is read-write; one means shared reference clock.
// R4: common clock selects which exit latencies are reported.
// R5: writing one to bit 5 sends the training machine to recovery.
// R6: bit 5 always reads zero and clears itself.
// R7: link disable bit disables link; clearing it retrains the link.
// R8: link disable reads back the written value at once.
// R9: bit 3 is hardwired zero, meaning 64-byte completion boundary.
// R10: bits 1:0 select aspm: off, l0s, l1 only, or both.
// R11: retrain write shows training pending until training completes.
// R12: bit 2 and reserved bits read zero and ignore writes.
// ---------------------------------------------------------------
`include "plc_regs.svh"
`default_nettype none
module plc_link_control
	import plc_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// configuration access, same clock domain
	input  wire logic [7:0]  cfgAddr,
	input  wire logic        cfgWrite,
	input  wire logic        cfgRead,
	input  wire logic [1:0]  cfgByteEn,
	input  wire logic [15:0] cfgWrData,
	output logic      [15:0] cfgRdData,
	// training state machine interface
	input  wire logic        trainActive,
	input  wire logic        trainDone,
	output logic             retrainReq,
	output logic             linkDisable,
	output logic             extSync,
	output logic             commonClk,
	output logic      [1:0]  aspmCtl,
	output logic             trainPending,
	output logic      [2:0]  l0sExitLat,
	output logic      [2:0]  l1ExitLat
);
	// -----------------------------------------------------------
	// register state
	// -----------------------------------------------------------
	logic       extSync_q, extSync_d;
	logic       commonClk_q, commonClk_d;
	logic       linkDisable_q, linkDisable_d;
	plc_aspm_t  aspm_q, aspm_d;
	logic       retrain_q, retrain_d;
	logic       pend_q, pend_d;
	logic       trainSync1_q, trainSync2_q;
	logic       doneSync1_q, doneSync2_q;
	// delayed copy of the synchronised active level, for its falling edge
	logic       trainPrev_q;
	logic       trainEnd;
	logic       wrHit, rdHit;
	logic       retrainWr;
	logic [15:0] rdVal_d, rdVal_q;

	// one decoder for both paths, so reads and writes cannot disagree
	function automatic logic hitsLinkCtl(input logic [7:0] addr);
		return addr == `PLC_LINK_CONTROL_OFF;
	endfunction : hitsLinkCtl

	assign wrHit = cfgWrite && hitsLinkCtl(cfgAddr) && cfgByteEn[0];
	assign rdHit = cfgRead && hitsLinkCtl(cfgAddr);
	assign retrainWr = wrHit && cfgWrData[`PLC_RETRAIN_BIT];
	// training counts as over only once it was seen active and has ended
	assign trainEnd = trainPrev_q && !trainSync2_q && doneSync2_q;

	// -----------------------------------------------------------
	// next values
	// -----------------------------------------------------------
	always_comb
	begin
		extSync_d     = extSync_q;
		commonClk_d   = commonClk_q;
		linkDisable_d = linkDisable_q;
		aspm_d        = aspm_q;
		// upper byte is reserved, so its lane is ignored
		if (wrHit) // R12
		begin
			extSync_d     = cfgWrData[`PLC_EXT_SYNC_BIT]; // R2
			commonClk_d   = cfgWrData[`PLC_COMMON_CLK_BIT]; // R3
			linkDisable_d = cfgWrData[`PLC_LINK_DISABLE_BIT]; // R8
			aspm_d = plc_aspm_t'(cfgWrData[`PLC_ASPM_HI:`PLC_ASPM_LO]); // R10
		end
		// retrain is a one-cycle pulse; a 1->0 on disable retrains too
		retrain_d = retrainWr
			|| (linkDisable_q && !linkDisable_d); // R5 R7
		// set wins over clear when a new request meets completion; a done
		// level left from an earlier training must not end a fresh request
		if (retrain_d)
			pend_d = 1'b1; // R11
		else if (trainEnd)
			pend_d = 1'b0; // R11
		else
			pend_d = pend_q;
		rdVal_d = 16'h0000; // R1
		rdVal_d[`PLC_EXT_SYNC_BIT]     = extSync_q;
		rdVal_d[`PLC_COMMON_CLK_BIT]   = commonClk_q;
		rdVal_d[`PLC_RETRAIN_BIT]      = 1'b0; // R6
		rdVal_d[`PLC_LINK_DISABLE_BIT] = linkDisable_q; // R8
		rdVal_d[`PLC_RCB_BIT]          = 1'b0; // R9
		rdVal_d[`PLC_ASPM_HI:`PLC_ASPM_LO] = aspm_q;
		if (!rdHit)
			rdVal_d = 16'h0000;
	end

	// -----------------------------------------------------------
	// registers
	// -----------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			extSync_q     <= 1'b0; // R1
			commonClk_q   <= 1'b0;
			linkDisable_q <= 1'b0;
			aspm_q        <= PLC_ASPM_OFF;
			retrain_q     <= 1'b0;
			pend_q        <= 1'b0;
			rdVal_q       <= `PLC_LINK_CONTROL_RST;
			trainSync1_q  <= 1'b0;
			trainSync2_q  <= 1'b0;
			doneSync1_q   <= 1'b0;
			doneSync2_q   <= 1'b0;
			trainPrev_q   <= 1'b0;
		end
		else
		begin
			extSync_q     <= extSync_d;
			commonClk_q   <= commonClk_d;
			linkDisable_q <= linkDisable_d;
			aspm_q        <= aspm_d;
			retrain_q     <= retrain_d; // R6
			pend_q        <= pend_d;
			rdVal_q       <= rdVal_d;
			// training status comes from the link side, so synchronise
			trainSync1_q  <= trainActive;
			trainSync2_q  <= trainSync1_q;
			doneSync1_q   <= trainDone;
			doneSync2_q   <= doneSync1_q;
			trainPrev_q   <= trainSync2_q;
		end
	end

	// -----------------------------------------------------------
	// outputs
	// -----------------------------------------------------------
	assign cfgRdData    = rdVal_q;
	assign retrainReq   = retrain_q; // R5
	assign linkDisable  = linkDisable_q; // R7
	assign extSync      = extSync_q;
	assign commonClk    = commonClk_q;
	assign aspmCtl      = aspm_q;
	assign trainPending = pend_q || trainSync2_q; // R11
	// async clocks need the longer l0s exit latency
	assign l0sExitLat = commonClk_q ? `PLC_L0S_LAT_COMMON
		: `PLC_L0S_LAT_ASYNC; // R4
	assign l1ExitLat  = commonClk_q ? `PLC_L1_LAT_COMMON
		: `PLC_L1_LAT_ASYNC; // R4

	// -----------------------------------------------------------
	// checks
	// -----------------------------------------------------------
	sequence s_disClear;
		linkDisable_q ##1 !linkDisable_q;
	endsequence

	a_retrain_pulse: assert property (@(posedge clk) disable iff (rst) // R5
		retrainWr |=> retrainReq ##1 (!retrainReq || $past(wrHit)))
		else $error("retrain write gave no pulse");
	a_retrain_reads0: assert property (@(posedge clk) disable iff (rst) // R6
		!cfgRdData[`PLC_RETRAIN_BIT])
		else $error("retrain bit read as one");
	a_disable_retrain: assert property (@(posedge clk) disable iff (rst) // R7
		s_disClear |-> retrainReq)
		else $error("disable clear did not retrain");
	a_disable_read: assert property (@(posedge clk) disable iff (rst) // R8
		rdHit ##1 1'b1 |-> cfgRdData[`PLC_LINK_DISABLE_BIT]
			== $past(linkDisable_q))
		else $error("disable readback wrong");
	a_rcb_zero: assert property (@(posedge clk) disable iff (rst) // R9
		!cfgRdData[`PLC_RCB_BIT] && !cfgRdData[2])
		else $error("hardwired bits not zero");
	a_upper_zero: assert property (@(posedge clk) disable iff (rst) // R1
		cfgRdData[15:8] == 8'h00)
		else $error("reserved byte not zero");
	a_aspm_write: assert property (@(posedge clk) disable iff (rst) // R10
		wrHit |=> aspmCtl == $past(cfgWrData[1:0]))
		else $error("aspm field not written");
	a_pend_set: assert property (@(posedge clk) disable iff (rst) // R11
		retrainWr |=> trainPending)
		else $error("training pending not shown");
	a_lat_common: assert property (@(posedge clk) disable iff (rst) // R4
		commonClk |-> l0sExitLat == `PLC_L0S_LAT_COMMON)
		else $error("wrong l0s latency");
	a_lat_async: assert property (@(posedge clk) disable iff (rst) // R4
		!commonClk |-> l0sExitLat == `PLC_L0S_LAT_ASYNC
			&& l1ExitLat == `PLC_L1_LAT_ASYNC)
		else $error("wrong latency for async clocks");
	a_disable_write: assert property (@(posedge clk) disable iff (rst) // R7
		wrHit |=> linkDisable
			== $past(cfgWrData[`PLC_LINK_DISABLE_BIT]))
		else $error("link disable not written");
	a_ignore_write: assert property (@(posedge clk) disable iff (rst) // R12
		!wrHit |=> $stable(aspmCtl) && $stable(extSync)
			&& $stable(commonClk) && $stable(linkDisable))
		else $error("register changed without a write");

	// end of one observed training, with no new request in the same cycle
	sequence s_trainEnd;
		trainSync2_q ##1 !trainSync2_q && doneSync2_q && !retrain_d;
	endsequence

	a_pend_clear: assert property (@(posedge clk) disable iff (rst) // R11
		s_trainEnd |=> !pend_q)
		else $error("training pending not cleared");
	a_pend_hold: assert property (@(posedge clk) disable iff (rst) // R11
		pend_q && !trainPrev_q |=> pend_q)
		else $error("pending cleared before training ran");
	a_pend_active: assert property (@(posedge clk) disable iff (rst) // R11
		trainSync2_q |-> trainPending)
		else $error("active training not shown as pending");
endmodule : plc_link_control
`default_nettype wire

// ---- hdl/plc_regs.svh ----
// register offsets, field positions, reset values and latency codes
`ifndef PLC_REGS_SVH
`define PLC_REGS_SVH
`define PLC_LINK_CONTROL_OFF   8'hb0
`define PLC_LINK_CONTROL_RST   16'h0000
`define PLC_EXT_SYNC_BIT       7
`define PLC_COMMON_CLK_BIT     6
`define PLC_RETRAIN_BIT        5
`define PLC_LINK_DISABLE_BIT   4
`define PLC_RCB_BIT            3
`define PLC_ASPM_LO            0
`define PLC_ASPM_HI            1
`define PLC_L0S_LAT_COMMON     3'h2
`define PLC_L0S_LAT_ASYNC      3'h4
`define PLC_L1_LAT_COMMON      3'h2
`define PLC_L1_LAT_ASYNC       3'h2
`endif

// ---- hdl/plc_pkg.sv ----
// types for the link control register block
`default_nettype none
package plc_pkg;
	typedef enum logic [1:0]
	{
		PLC_ASPM_OFF = 2'h0,
		PLC_ASPM_L0S = 2'h1,
		PLC_ASPM_L1  = 2'h2,
		PLC_ASPM_ALL = 2'h3
	} plc_aspm_t;
endpackage : plc_pkg
`default_nettype wire

// ---- bench/plc_train_model.sv ----
// training state machine model facing the link control block
`default_nettype none
module plc_train_model
#(parameter int DLY = 6)
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// control from the register block
	input  wire logic retrainReq,
	input  wire logic linkDisable,
	// status to the register block
	output logic      trainActive,
	output logic      trainDone
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	always_comb
	begin
		cnt_d = cnt_q;
		if (retrainReq)
			cnt_d = 4'h1;
		else if (cnt_q != 4'h0 && cnt_q < 4'(DLY))
			cnt_d = cnt_q + 4'h1;
	end
	always_ff @(posedge clk)
		cnt_q <= rst ? 4'h0 : cnt_d;
	// a disabled link never enters recovery
	assign trainActive = cnt_q > 4'h1 && cnt_q < 4'(DLY) && !linkDisable;
	assign trainDone = cnt_q == 4'(DLY);
endmodule : plc_train_model
`default_nettype wire

// ---- bench/pcie_link_control_register_tb.sv ----
// self-checking bench for the link control register
`include "plc_regs.svh"
`default_nettype none
`define CHK(a, b) \
	if ((a) !== (b)) \
	begin \
		failures++; \
		$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); \
	end \
	testsRun++;
module pcie_link_control_register_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst, cfgWrite, cfgRead, trainActive, trainDone;
	logic retrainReq, linkDisable, extSync, commonClk, trainPending;
	logic [7:0] cfgAddr;
	logic [1:0] cfgByteEn, aspmCtl;
	logic [15:0] cfgWrData, cfgRdData;
	logic [2:0] l0sExitLat, l1ExitLat;
	logic [2:0] l0sExp, l1Exp;
	int failures, testsRun, cyc;
	// rows: written word beside the word read back
	logic [15:0] wrV [6] = '{16'hffff, 16'h0000, 16'h0041, 16'h0002,
		16'h0083, 16'h0047};
	logic [15:0] expV [6] = '{16'h00d3, 16'h0000, 16'h0041, 16'h0002,
		16'h0083, 16'h0043};
	// retrain pulse each row should give: bit 5 set, or disable cleared
	logic rtV [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
	plc_link_control dut_u (.clk, .rst, .cfgAddr, .cfgWrite, .cfgRead,
		.cfgByteEn, .cfgWrData, .cfgRdData, .trainActive, .trainDone,
		.retrainReq, .linkDisable, .extSync, .commonClk, .aspmCtl,
		.trainPending, .l0sExitLat, .l1ExitLat);
	plc_train_model model_u (.clk, .rst, .retrainReq, .linkDisable,
		.trainActive, .trainDone);
	always #12.5 clk = ~clk;
	task automatic report_and_stop;
		$display("comparisons=%0d mismatches=%0d", testsRun, failures);
		if (failures == 0 && testsRun > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	// ceiling well above the fewer than a hundred cycles the tests need
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			failures++;
			report_and_stop;
		end
	end
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		cfgAddr <= a;
		cfgWrData <= d;
		cfgWrite <= 1'b1;
		@(posedge clk);
		cfgWrite <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		cfgAddr <= a;
		cfgRead <= 1'b1;
		@(posedge clk);
		cfgRead <= 1'b0;
		#1;
		`CHK(cfgRdData, e)
	endtask : rd
	initial
	begin
		clk = 0; rst = 1; cfgAddr = 8'h00; cfgWrite = 0; cfgRead = 0;
		cfgByteEn = 2'h3; cfgWrData = 16'h0000;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(`PLC_LINK_CONTROL_OFF, `PLC_LINK_CONTROL_RST);
		`CHK(l0sExitLat, `PLC_L0S_LAT_ASYNC)
		`CHK(l1ExitLat, `PLC_L1_LAT_ASYNC)
		`CHK(trainPending, 1'b0)
		$display("test reset done");
		for (int i = 0; i < 6; i++)
		begin
			wr(`PLC_LINK_CONTROL_OFF, wrV[i]);
			`CHK(aspmCtl, expV[i][1:0])
			`CHK(extSync, expV[i][7])
			`CHK(commonClk, expV[i][6])
			l0sExp = expV[i][6] ? `PLC_L0S_LAT_COMMON
				: `PLC_L0S_LAT_ASYNC;
			l1Exp = expV[i][6] ? `PLC_L1_LAT_COMMON
				: `PLC_L1_LAT_ASYNC;
			`CHK(l0sExitLat, l0sExp)
			`CHK(l1ExitLat, l1Exp)
			`CHK(retrainReq, rtV[i])
			`CHK(linkDisable, expV[i][4])
			rd(`PLC_LINK_CONTROL_OFF, expV[i]);
		end
		$display("test table done");
		wr(`PLC_LINK_CONTROL_OFF, 16'h0020);
		`CHK(retrainReq, 1'b1)
		`CHK(trainPending, 1'b1)
		@(posedge clk);
		#1;
		`CHK(retrainReq, 1'b0)
		`CHK(trainPending, 1'b1)
		for (int n = 0; n < 20 && trainPending !== 1'b0; n++)
		begin
			@(posedge clk);
			#1;
		end
		`CHK(trainPending, 1'b0)
		$display("test retrain done");
		wr(`PLC_LINK_CONTROL_OFF, 16'h0010);
		`CHK(linkDisable, 1'b1)
		rd(`PLC_LINK_CONTROL_OFF, 16'h0010);
		wr(`PLC_LINK_CONTROL_OFF, 16'h0000);
		`CHK(retrainReq, 1'b1)
		$display("test disable done");
		wr(`PLC_LINK_CONTROL_OFF, 16'h00c3);
		`CHK(commonClk, 1'b1)
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		`CHK(aspmCtl, 2'h0)
		`CHK(extSync, 1'b0)
		`CHK(commonClk, 1'b0)
		`CHK(trainPending, 1'b0)
		`CHK(l0sExitLat, `PLC_L0S_LAT_ASYNC)
		rd(`PLC_LINK_CONTROL_OFF, `PLC_LINK_CONTROL_RST);
		$display("test mid-run reset done");
		wr(8'hb2, 16'h00ff);
		rd(8'hb2, 16'h0000);
		rd(`PLC_LINK_CONTROL_OFF, 16'h0000);
		@(posedge clk);
		cfgByteEn <= 2'h2;
		wr(`PLC_LINK_CONTROL_OFF, 16'h0003);
		rd(`PLC_LINK_CONTROL_OFF, 16'h0000);
		$display("test refused done");
		report_and_stop;
	end
endmodule : pcie_link_control_register_tb
`default_nettype wire
